/* hdl/rbc_pkg.sv */
// Shared constants and types of the reset, boot and clock source block
package rbc_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] REG_PULLUP_DISABLE = 4'h0;
  localparam logic [ADDR_W-1:0] REG_OSC_CONTROL = 4'h1;
  localparam logic [ADDR_W-1:0] REG_BOOT_STATUS = 4'h2;
  localparam logic [ADDR_W-1:0] REG_RESET_CAUSE = 4'h3;
  localparam logic [ADDR_W-1:0] REG_RESET_CONTROL = 4'h4;

  // Pull-up disable register fields
  localparam int PUD_RESET_BIT = 0;
  localparam int PUD_BOOT_BIT = 1;
  localparam int PUD_MEMMODE_BIT = 2;
  localparam logic [2:0] PUD_RESET_VALUE = 3'h0;

  // Oscillator control register fields
  localparam int OSC_DRIVE_BIT = 0;
  localparam logic OSC_DRIVE_RESET_VALUE = 1'b0;

  // Boot status register fields
  localparam int STS_BOOT_EXT_BIT = 0;
  localparam int STS_ADDR20_BIT = 1;
  localparam int STS_SECURED_BIT = 2;
  localparam int STS_CLOCK_INPUT_MODE_BIT = 3;
  localparam int STS_CLKSRC_LSB = 4;

  // Reset cause register fields
  localparam int CAUSE_POWERON_BIT = 0;
  localparam int CAUSE_PIN_BIT = 1;
  localparam int CAUSE_SOFT_BIT = 2;
  localparam logic [2:0] CAUSE_RESET_VALUE = 3'h1;

  // Reset control register fields
  localparam int CTRL_SOFT_RESET_BIT = 0;

  // Cycles between the last reset source going away and the release
  localparam int RELEASE_CYCLES_DEFAULT = 64;

  // Level of the boot straps when they are not bonded out
  localparam logic STRAP_TIE_LEVEL = 1'b0;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_RELEASE = 2'b01,
    ST_RUN = 2'b11
  } rbc_state_e;

  typedef enum logic [1:0] {
    SRC_RESONATOR = 2'b00,
    SRC_CRYSTAL = 2'b01,
    SRC_EXT_CLOCK = 2'b10
  } rbc_clksrc_e;

endpackage

/* hdl/rbc_rel_if.sv */
// Handshake between the reset sequencer and its release counter
`timescale 1ns/1ns
interface rbc_rel_if;
  logic run;
  logic done;
  modport ctl (output run, input done);
  modport cnt (input run, output done);
endinterface

/* hdl/rbc_release_counter.sv */
// Counts the fixed reset release delay
`timescale 1ns/1ns
module rbc_release_counter #(
  parameter int CYCLES = rbc_pkg::RELEASE_CYCLES_DEFAULT
) (
  input wire logic clk,
  input wire logic rstN,
  rbc_rel_if.cnt rel
);
  import rbc_pkg::*;

  localparam int CNT_W = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : gBadCycles
    $error("Release delay must be at least one cycle");
  end

  logic [CNT_W-1:0] count_r;

  // Count while run is high, restart whenever it drops
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      count_r <= '0;
    end else if (!rel.run) begin
      count_r <= '0;
    end else if (count_r != CNT_W'(CYCLES)) begin
      count_r <= count_r + CNT_W'(1);
    end
  end

  assign rel.done = rel.run && (count_r == CNT_W'(CYCLES - 1));

endmodule

/* hdl/rbc_reset_boot_clock.sv */
// Reset sequencer, boot strap capture and oscillator source configuration
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
module rbc_reset_boot_clock #(
  parameter int RELEASE_CYCLES = rbc_pkg::RELEASE_CYCLES_DEFAULT,
  parameter bit STRAPS_BONDED = 1'b0
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic extResetN,
  input wire logic testResetN,
  input wire logic externalBootSelect,
  input wire logic externalMemoryMode,
  input wire logic flashSecured,
  input wire logic clockInputMode,
  input wire logic [rbc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [rbc_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [rbc_pkg::DATA_W-1:0] regRdata,
  output logic resetOutN,
  output logic debugResetN,
  output logic resetPullupEn,
  output logic bootPullupEn,
  output logic memModePullupEn,
  output logic oscDriveSelect,
  output logic bootExternal,
  output logic externalAddr20
);
  import rbc_pkg::*;

  if (RELEASE_CYCLES < 1) begin : gBadRelease
    $error("Release delay must be at least one cycle");
  end

  // Power-on reset release through two flip-flops
  logic porSync1_r;
  logic porSync2_r;
  logic rstN;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      porSync1_r <= 1'b0;
      porSync2_r <= 1'b0;
    end else begin
      porSync1_r <= 1'b1;
      porSync2_r <= porSync1_r;
    end
  end

  assign rstN = porSync2_r;

  // Register state
  logic resetPullupOff_r;
  logic bootPullupOff_r;
  logic memModePullupOff_r;
  logic oscDrive_r;
  logic [2:0] cause_r;
  logic [2:0] cause_nxt;
  logic softReset_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // Sequencer state
  rbc_state_e state_r;
  rbc_state_e state_nxt;
  logic resetOutN_r;
  logic debugResetN_r;
  logic firstRun_r;
  logic anySource;
  logic intReset;

  // Boot straps captured at release
  logic bootExt_r;
  logic addr20_r;
  logic secured_r;

  rbc_rel_if rel ();

  rbc_release_counter #(
    .CYCLES(RELEASE_CYCLES)
  ) u_release (
    .clk(sys_clk),
    .rstN(rstN),
    .rel(rel)
  );

  function automatic logic regHit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offset);
    regHit = (addr == offset);
  endfunction

  // Strap levels seen by the boot logic
  logic bootStrap;
  logic memModeStrap;

  assign bootStrap = STRAPS_BONDED ? externalBootSelect : STRAP_TIE_LEVEL;
  assign memModeStrap = STRAPS_BONDED ? externalMemoryMode : STRAP_TIE_LEVEL;

  // Reset sources: power-on is handled by rstN itself, the pin and software here
  assign anySource = !extResetN || softReset_r;
  assign intReset = (state_r != ST_RUN);
  assign rel.run = (state_r == ST_RELEASE) && !anySource;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_HOLD: begin
        if (!anySource) begin
          state_nxt = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (anySource) begin
          state_nxt = ST_HOLD;
        end else if (rel.done) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (anySource) begin
          state_nxt = ST_HOLD;
        end
      end
      default: begin
        state_nxt = ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= ST_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Reset output driven from the same next state as the sequencer
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      resetOutN_r <= 1'b0;
    end else begin
      resetOutN_r <= (state_nxt == ST_RUN);
    end
  end

  // Debug logic is reset by test reset or power-on, never by the reset pin alone
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      debugResetN_r <= 1'b0;
    end else begin
      debugResetN_r <= testResetN;
    end
  end

  // Boot mode captured once as the internal reset releases
  logic releaseEdge;

  assign releaseEdge = (state_r == ST_RELEASE) && (state_nxt == ST_RUN);

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      bootExt_r <= 1'b0;
    end else if (releaseEdge) begin
      bootExt_r <= bootStrap && !flashSecured;
    end
  end

  // Wide external addressing needs the memory mode strap as well
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      addr20_r <= 1'b0;
    end else if (releaseEdge) begin
      addr20_r <= bootStrap && !flashSecured && memModeStrap;
    end
  end

  // Security state seen at release, kept until the next release
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      secured_r <= 1'b0;
    end else if (releaseEdge) begin
      secured_r <= flashSecured;
    end
  end

  // Marks the first release after power-up
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      firstRun_r <= 1'b0;
    end else if (state_r == ST_RUN) begin
      firstRun_r <= 1'b1;
    end
  end

  // Pull-up disable bits, each cleared by every internal reset
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      resetPullupOff_r <= PUD_RESET_VALUE[PUD_RESET_BIT];
    end else if (intReset) begin
      resetPullupOff_r <= PUD_RESET_VALUE[PUD_RESET_BIT];
    end else if (regWrite && regHit(regAddr, REG_PULLUP_DISABLE)) begin
      resetPullupOff_r <= regWdata[PUD_RESET_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      bootPullupOff_r <= PUD_RESET_VALUE[PUD_BOOT_BIT];
    end else if (intReset) begin
      bootPullupOff_r <= PUD_RESET_VALUE[PUD_BOOT_BIT];
    end else if (regWrite && regHit(regAddr, REG_PULLUP_DISABLE)) begin
      bootPullupOff_r <= regWdata[PUD_BOOT_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      memModePullupOff_r <= PUD_RESET_VALUE[PUD_MEMMODE_BIT];
    end else if (intReset) begin
      memModePullupOff_r <= PUD_RESET_VALUE[PUD_MEMMODE_BIT];
    end else if (regWrite && regHit(regAddr, REG_PULLUP_DISABLE)) begin
      memModePullupOff_r <= regWdata[PUD_MEMMODE_BIT];
    end
  end

  // Oscillator control register, drive select only
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      oscDrive_r <= OSC_DRIVE_RESET_VALUE;
    end else if (intReset) begin
      oscDrive_r <= OSC_DRIVE_RESET_VALUE;
    end else if (regWrite && regHit(regAddr, REG_OSC_CONTROL)) begin
      oscDrive_r <= regWdata[OSC_DRIVE_BIT];
    end
  end

  // Clock source seen from the mode input and the drive select bit
  rbc_clksrc_e clockSource;

  always_comb begin
    if (clockInputMode) begin
      clockSource = SRC_EXT_CLOCK;
    end else if (oscDrive_r) begin
      clockSource = SRC_CRYSTAL;
    end else begin
      clockSource = SRC_RESONATOR;
    end
  end

  // Software reset request, held until the sequencer is in reset
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      softReset_r <= 1'b0;
    end else if (intReset) begin
      softReset_r <= 1'b0;
    end else if (regWrite && regHit(regAddr, REG_RESET_CONTROL)) begin
      softReset_r <= regWdata[CTRL_SOFT_RESET_BIT];
    end
  end

  // Sticky reset cause, write one to clear, a new cause wins over the clear
  always_comb begin
    cause_nxt = cause_r;
    if (regWrite && regHit(regAddr, REG_RESET_CAUSE)) begin
      cause_nxt = cause_r & ~regWdata[2:0];
    end
    if (!firstRun_r) begin
      cause_nxt[CAUSE_POWERON_BIT] = 1'b1;
    end
    if (!extResetN) begin
      cause_nxt[CAUSE_PIN_BIT] = 1'b1;
    end
    if (softReset_r) begin
      cause_nxt[CAUSE_SOFT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      cause_r <= CAUSE_RESET_VALUE;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // Read data, one cycle after the strobe
  always_comb begin
    rdata_nxt = '0;
    case (regAddr)
      REG_PULLUP_DISABLE: begin
        rdata_nxt[PUD_RESET_BIT] = resetPullupOff_r;
        rdata_nxt[PUD_BOOT_BIT] = bootPullupOff_r;
        rdata_nxt[PUD_MEMMODE_BIT] = memModePullupOff_r;
      end
      REG_OSC_CONTROL: begin
        rdata_nxt[OSC_DRIVE_BIT] = oscDrive_r;
      end
      REG_BOOT_STATUS: begin
        rdata_nxt[STS_BOOT_EXT_BIT] = bootExt_r;
        rdata_nxt[STS_ADDR20_BIT] = addr20_r;
        rdata_nxt[STS_SECURED_BIT] = secured_r;
        rdata_nxt[STS_CLOCK_INPUT_MODE_BIT] = clockInputMode;
        rdata_nxt[STS_CLKSRC_LSB +: 2] = clockSource;
      end
      REG_RESET_CAUSE: begin
        rdata_nxt[2:0] = cause_r;
      end
      REG_RESET_CONTROL: begin
        rdata_nxt[CTRL_SOFT_RESET_BIT] = softReset_r;
      end
      default: begin
        rdata_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rdata_r <= '0;
    end else if (regRead) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end

  assign regRdata = rdata_r;
  assign resetOutN = resetOutN_r;
  assign debugResetN = debugResetN_r;
  assign resetPullupEn = !resetPullupOff_r;
  assign bootPullupEn = !bootPullupOff_r;
  assign memModePullupEn = !memModePullupOff_r;
  assign oscDriveSelect = oscDrive_r;
  assign bootExternal = bootExt_r;
  assign externalAddr20 = addr20_r;

endmodule

/* sim/rbc_reset_boot_clock_properties.sv */
// Port checks of the reset, boot and clock source block
`timescale 1ns/1ns
module rbc_reset_boot_clock_properties
  import rbc_pkg::*;
#(
  parameter int RELEASE_CYCLES = RELEASE_CYCLES_DEFAULT,
  parameter bit STRAPS_BONDED = 1'b0
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic extResetN,
  input wire logic testResetN,
  input wire logic [rbc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [rbc_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [rbc_pkg::DATA_W-1:0] regRdata,
  input wire logic resetOutN,
  input wire logic debugResetN,
  input wire logic resetPullupEn,
  input wire logic bootPullupEn,
  input wire logic memModePullupEn,
  input wire logic oscDriveSelect,
  input wire logic bootExternal,
  input wire logic externalAddr20
);
  logic [7:0] lowRun_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Cycles the reset output stays low after the pin went high
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lowRun_r <= 8'h00;
    end else if (resetOutN || !extResetN) begin
      lowRun_r <= 8'h00;
    end else if (lowRun_r != 8'hff) begin
      lowRun_r <= lowRun_r + 8'h01;
    end
  end
  chk_pin_asserts: assert property (!extResetN |=> !resetOutN)
    else $error("reset output not low after pin reset");
  chk_release_wait: assert property ($rose(extResetN) |-> !resetOutN [*2])
    else $error("reset output released too early");
  chk_release_bound: assert property (lowRun_r <= RELEASE_CYCLES + 6)
    else $error("reset output held too long");
  chk_regs_cleared: assert property (!resetOutN [*2] |->
    !oscDriveSelect && resetPullupEn && bootPullupEn && memModePullupEn)
    else $error("registers not cleared in reset");
  chk_osc_write: assert property (regWrite && resetOutN && extResetN && regAddr == REG_OSC_CONTROL
    |=> oscDriveSelect == $past(regWdata[OSC_DRIVE_BIT]))
    else $error("drive select not written");
  chk_pullup_write: assert property (regWrite && resetOutN && extResetN && regAddr == REG_PULLUP_DISABLE
    |=> resetPullupEn != $past(regWdata[PUD_RESET_BIT]) && bootPullupEn != $past(regWdata[PUD_BOOT_BIT]))
    else $error("pull-up enables not written");
  chk_boot_internal: assert property (!STRAPS_BONDED |-> !bootExternal && !externalAddr20)
    else $error("external boot selected");
  chk_debug_full: assert property (!testResetN |=> !debugResetN)
    else $error("debug reset not asserted");
  chk_debug_kept: assert property (!extResetN && testResetN && debugResetN |=> debugResetN)
    else $error("debug reset disturbed by pin reset");
  chk_read_idle: assert property (!$past(regRead) |-> regRdata == '0)
    else $error("read data outside read cycle");
endmodule
bind rbc_reset_boot_clock rbc_reset_boot_clock_properties #(
  .RELEASE_CYCLES(RELEASE_CYCLES),
  .STRAPS_BONDED(STRAPS_BONDED)
) u_chk (
  .sys_clk, .resetn, .extResetN, .testResetN, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
  .resetOutN, .debugResetN, .resetPullupEn, .bootPullupEn, .memModePullupEn, .oscDriveSelect,
  .bootExternal, .externalAddr20
);

/* sim/rbc_reset_partner.sv */
// External reset source and debugger model
`timescale 1ns/1ns
module rbc_reset_partner (
  input wire logic sys_clk,
  input wire logic fullReq,
  input wire logic devReq,
  output logic extResetN,
  output logic testResetN
);
  initial begin
    extResetN = 1'b1;
    testResetN = 1'b1;
  end
  always @(posedge sys_clk) begin
    extResetN <= !(fullReq || devReq);
    testResetN <= !fullReq;
  end
endmodule

/* sim/rbc_reset_boot_clock_tb_top.sv */
// Self-checking bench of the reset, boot and clock source block
`timescale 1ns/1ns
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin errTotal++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module rbc_reset_boot_clock_tb_top;
  import rbc_pkg::*;
  localparam int REL = 2;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic fullReq = 1'b0;
  logic devReq = 1'b0;
  logic bootSel = 1'b0;
  logic memMode = 1'b0;
  logic clock_input_mode = 1'b0;
  logic secured = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWdata = '0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [DATA_W-1:0] regRdata;
  logic extResetN, testResetN, resetOutN, debugResetN, resetPullupEn, bootPullupEn, memModePullupEn;
  logic oscDriveSelect, bootExternal, externalAddr20;
  int errTotal = 0;
  int compares = 0;
  always #10 sys_clk = ~sys_clk;
  rbc_reset_partner u_partner (.sys_clk, .fullReq, .devReq, .extResetN, .testResetN);
  rbc_reset_boot_clock #(.RELEASE_CYCLES(REL)) u_dut (
    .sys_clk, .resetn, .extResetN, .testResetN, .externalBootSelect(bootSel), .externalMemoryMode(memMode),
    .flashSecured(secured), .clockInputMode(clock_input_mode), .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .resetOutN, .debugResetN, .resetPullupEn, .bootPullupEn, .memModePullupEn, .oscDriveSelect,
    .bootExternal, .externalAddr20
  );
  task automatic endOfTest();
    $display("compares %0d mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string n);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    `CHK(n, e, regRdata)
    @(posedge sys_clk);
  endtask
  task automatic waitOut(input logic lvl, output int n);
    n = 0;
    while (resetOutN !== lvl) begin
      @(negedge sys_clk);
      n++;
      if (n > 60) begin
        errTotal++;
        endOfTest();
      end
    end
    @(posedge sys_clk);
  endtask
  task automatic t_power();
    int n;
    waitOut(1'b1, n);
    `CHK("oscDrive", OSC_DRIVE_RESET_VALUE, oscDriveSelect)
    `CHK("pullups", 3'h7, {resetPullupEn, bootPullupEn, memModePullupEn})
    rd(REG_PULLUP_DISABLE, 16'h0000, "pullupReg");
    rd(REG_RESET_CAUSE, 16'h0001, "cause");
    rd(REG_BOOT_STATUS, 16'h0000, "status");
    $display("test power done");
  endtask
  task automatic t_regs();
    wr(REG_PULLUP_DISABLE, 16'h0007);
    rd(REG_PULLUP_DISABLE, 16'h0007, "pullupReg");
    `CHK("pullups", 3'h0, {resetPullupEn, bootPullupEn, memModePullupEn})
    wr(REG_PULLUP_DISABLE, 16'h0001);
    rd(4'hf, 16'h0000, "unmapped");
    `CHK("pullups", 3'h3, {resetPullupEn, bootPullupEn, memModePullupEn})
    clock_input_mode <= 1'b1;
    wr(REG_OSC_CONTROL, 16'h0001);
    rd(REG_OSC_CONTROL, 16'h0001, "oscReg");
    `CHK("oscDrive", 1'b1, oscDriveSelect)
    rd(REG_BOOT_STATUS, 16'h0028, "status");
    clock_input_mode <= 1'b0;
    rd(REG_BOOT_STATUS, 16'h0010, "status");
    $display("test regs done");
  endtask
  task automatic t_pin(input logic full);
    int n;
    fullReq <= full;
    devReq <= !full;
    secured <= !full;
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK("resetOut", 1'b0, resetOutN)
    `CHK("debugReset", !full, debugResetN)
    `CHK("oscDrive", 1'b0, oscDriveSelect)
    `CHK("pullups", 3'h7, {resetPullupEn, bootPullupEn, memModePullupEn})
    @(posedge sys_clk);
    fullReq <= 1'b0;
    devReq <= 1'b0;
    waitOut(1'b1, n);
    `CHK("release", 1'b1, n >= REL + 2 && n <= REL + 4)
    `CHK("boot", 2'h0, {bootExternal, externalAddr20})
    rd(REG_BOOT_STATUS, full ? 16'h0000 : 16'h0004, "status");
    $display("test pin reset done");
  endtask
  task automatic t_soft();
    int n;
    wr(REG_OSC_CONTROL, 16'h0001);
    wr(REG_RESET_CONTROL, 16'h0001);
    waitOut(1'b0, n);
    `CHK("softLow", 1'b1, n <= 3)
    waitOut(1'b1, n);
    `CHK("oscDrive", 1'b0, oscDriveSelect)
    rd(REG_RESET_CAUSE, 16'h0007, "cause");
    wr(REG_RESET_CAUSE, 16'h0007);
    rd(REG_RESET_CAUSE, 16'h0000, "causeClear");
    $display("test soft reset done");
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    t_power();
    t_regs();
    t_pin(1'b1);
    bootSel <= 1'b1;
    memMode <= 1'b1;
    t_pin(1'b0);
    t_soft();
    endOfTest();
  end
endmodule
